//--- logic/prs_readout.sv
// Pressure sensor readout: I2C target, register file, conversion sequencer
// Assumes scl/sda pins with pull-ups outside and a front end on the clock domain
//
// Notes on behaviour
// - Answer as I2C target at seven-bit address 0x6D.
// - Start condition is SDA falling while SCL is high.
// - After start, seven address bits then one read/write direction bit.
// - On own address, pull SDA low during the ninth clock.
// - Stop condition is SDA rising while SCL is high.
// - Driven SDA stays stable while SCL high, changes only while low.
// - Pressure result is 24 bits read-only, MSB byte 0x06, LSB byte 0x08.
// - Temperature result is 16 bits read-only, high 0x09, low 0x0A.
// - Idle field bits 7:4 gives 62.5 ms steps, periodic mode only.
// - Start bit begins conversion, self-clears at end except periodic mode.
// - Select code 010 runs one temperature then pressure conversion.
// - Select code 011 repeats combined conversions spaced by idle interval.
// - Regulator select bit picks 1.8 V when clear, 3.6 V when set.
// - Unsigned bit gives unsigned output, only when raw output selected.
// - Raw select gives calibrated data when clear, raw converter data when set.
// - Diagnosis enable bit turns diagnosis on and defaults to one.
// - Input exchange bit swaps positive and negative sensor inputs.
// - Gain field bits 5:3 selects gain 1 to 128 in powers of two.
// - Oversampling field bits 2:0 selects ratio per fixed code table.
// - Pressure MSB is the sign bit, two's complement.
// - Temperature top bit is the sign, degrees Celsius times 256.
`timescale 1ns/1ps
`include "prs_defs.svh"

module prs_readout #(
  parameter int unsigned STEP_CYC = `PRS_IDLE_STEP_US * `PRS_CLK_MHZ
) (
  // System clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // I2C link
  input  wire logic                  link_clk,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_n,
  // Analog front end
  output prs_pkg::prs_afe_ctl_t      afe_ctl,
  input  wire prs_pkg::prs_afe_res_t afe_res
);
  import prs_pkg::*;
  function automatic logic [23:0] prs_fmt(input logic [23:0] raw, input logic [23:0] cal,
                                          input logic use_raw, input logic unip,
                                          input logic [23:0] msb);
    return use_raw ? (unip ? (raw ^ msb) : raw) : cal;
  endfunction
  // Link domain
  logic         scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  logic         ak_s1, ak_s2, ak_s3;
  prs_link_st_t st_q, st_d;
  logic [2:0]   cnt_q, cnt_d;
  logic [7:0]   sr_q, sr_d, tx_q, tx_d, idx_q, idx_d, rbuf_q;
  logic         drv_q, drv_d, to_tx_q, to_tx_d, first_q, first_d;
  logic         rq_tgl_q, pend_q, iss;
  prs_req_t     req_q, req_d;
  logic         ack_tgl_q;
  logic [7:0]   rdata_q;
  wire       rise    = scl_s2 & ~scl_s3;
  wire       fall    = ~scl_s2 & scl_s3;
  wire       start   = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire       stop    = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  wire [7:0] byte_in = {sr_q[6:0], sda_s2};
  wire       adr_hit = (sr_q[6:0] == `PRS_I2C_ADDR);
  wire       ack_new = ak_s2 ^ ak_s3;
  wire       iss_ok  = iss & ~pend_q;
  assign sda_o    = 1'b0;
  assign sda_oe_n = ~drv_q;
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
      {ak_s1, ak_s2, ak_s3}    <= 3'h0;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
      {ak_s1, ak_s2, ak_s3}    <= {ack_tgl_q, ak_s1, ak_s2};
    end
  end

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    sr_d    = sr_q;
    tx_d    = tx_q;
    idx_d   = idx_q;
    drv_d   = drv_q;
    to_tx_d = to_tx_q;
    first_d = first_q;
    iss     = 1'b0;
    req_d   = req_q;
    if (stop) begin
      st_d  = L_IDLE;
      drv_d = 1'b0;
    end else if (start) begin
      st_d  = L_ADDR;
      cnt_d = 3'h0;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        L_ADDR: if (rise) begin
          sr_d  = byte_in;
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            st_d    = adr_hit ? L_ACK : L_IDLE;
            to_tx_d = sda_s2;
            first_d = 1'b1;
          end
        end
        L_RX: if (rise) begin
          sr_d  = byte_in;
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            st_d    = L_ACK;
            to_tx_d = 1'b0;
            first_d = 1'b0;
            iss     = 1'b1;
            if (first_q) begin
              idx_d = byte_in;
              req_d = '{we: 1'b0, waddr: idx_q, wdata: 8'h00, raddr: byte_in};
            end else begin
              idx_d = idx_q + 8'h01;
              req_d = '{we: 1'b1, waddr: idx_q, wdata: byte_in, raddr: idx_q + 8'h01};
            end
          end
        end
        L_ACK: if (fall) begin
          if (!drv_q) begin
            drv_d = 1'b1;
          end else if (to_tx_q) begin
            st_d  = L_TX;
            cnt_d = 3'h0;
            tx_d  = {rbuf_q[6:0], 1'b0};
            drv_d = ~rbuf_q[7];
          end else begin
            st_d  = L_RX;
            cnt_d = 3'h0;
            drv_d = 1'b0;
          end
        end
        L_TX: begin
          if (rise) begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              st_d  = L_MACK;
              iss   = 1'b1;
              idx_d = idx_q + 8'h01;
              req_d = '{we: 1'b0, waddr: idx_q, wdata: 8'h00, raddr: idx_q + 8'h01};
            end
          end else if (fall) begin
            drv_d = ~tx_q[7];
            tx_d  = {tx_q[6:0], 1'b0};
          end
        end
        L_MACK: begin
          if (fall) begin
            drv_d = 1'b0;
          end else if (rise) begin
            st_d = sda_s2 ? L_IDLE : L_TXW;
          end
        end
        L_TXW: if (fall) begin
          st_d  = L_TX;
          cnt_d = 3'h0;
          tx_d  = {rbuf_q[6:0], 1'b0};
          drv_d = ~rbuf_q[7];
        end
        default: st_d = L_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      st_q     <= L_IDLE;
      cnt_q    <= 3'h0;
      sr_q     <= 8'h00;
      tx_q     <= 8'h00;
      idx_q    <= 8'h00;
      drv_q    <= 1'b0;
      to_tx_q  <= 1'b0;
      first_q  <= 1'b0;
      rbuf_q   <= 8'h00;
      req_q    <= '0;
      rq_tgl_q <= 1'b0;
      pend_q   <= 1'b0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      sr_q     <= sr_d;
      tx_q     <= tx_d;
      idx_q    <= idx_d;
      drv_q    <= drv_d;
      to_tx_q  <= to_tx_d;
      first_q  <= first_d;
      rbuf_q   <= ack_new ? rdata_q : rbuf_q;
      req_q    <= iss_ok ? req_d : req_q;
      rq_tgl_q <= rq_tgl_q ^ iss_ok;
      pend_q   <= iss_ok | (pend_q & ~ack_new);
    end
  end

  // System domain
  logic         rq_s1, rq_s2, rq_s3;
  logic [7:0]   cmd_q, cmd_d, sys_q, pcfg_q;
  logic [23:0]  pres_q;
  logic [15:0]  temp_q;
  prs_conv_st_t c_st_q, c_st_d;
  logic [31:0]  step_q;
  logic [3:0]   slp_q;
  logic         clr_sco;
  wire       new_req  = rq_s2 ^ rq_s3;
  wire       wr_en    = new_req & req_q.we;
  wire       wr_cmd   = wr_en & (req_q.waddr == `PRS_OFF_CMD);
  wire       sco      = cmd_q[`PRS_CMD_SCO];
  wire [2:0] mode     = cmd_q[`PRS_CMD_MODE_HI:`PRS_CMD_MODE_LO];
  wire [3:0] idle     = cmd_q[`PRS_CMD_IDLE_HI:`PRS_CMD_IDLE_LO];
  wire       periodic = (mode == `PRS_MODE_PERIOD);
  wire       mode_ok  = (mode == `PRS_MODE_SINGLE) | periodic;
  wire       use_raw  = sys_q[`PRS_SYS_RAW];
  wire       unip     = sys_q[`PRS_SYS_UNIP];
  wire       step_end = (step_q == 32'(STEP_CYC - 1));
  wire       conv_go  = (c_st_q == C_IDLE) & sco & mode_ok;
  wire [23:0] pres_v  = prs_fmt(afe_res.raw, afe_res.cal, use_raw, unip, `PRS_PRES_MSB);
  wire [23:0] temp_v  = prs_fmt(afe_res.raw, afe_res.cal, use_raw, unip, `PRS_TEMP_MSB);
  wire [7:0]  ra      = req_q.raddr;
  wire [7:0]  rd_val  = (ra == `PRS_OFF_PRES_H) ? pres_q[23:16] :
                        (ra == `PRS_OFF_PRES_M) ? pres_q[15:8]  :
                        (ra == `PRS_OFF_PRES_L) ? pres_q[7:0]   :
                        (ra == `PRS_OFF_TEMP_H) ? temp_q[15:8]  :
                        (ra == `PRS_OFF_TEMP_L) ? temp_q[7:0]   :
                        (ra == `PRS_OFF_CMD)    ? cmd_q         :
                        (ra == `PRS_OFF_SYS)    ? sys_q         :
                        (ra == `PRS_OFF_PCFG)   ? pcfg_q        : 8'h00;
  // Front end controls from the configuration registers, start and chan_pres from the sequencer state
  assign afe_ctl = '{regulator_select:   sys_q[`PRS_SYS_LDO],
                     diag_en:            sys_q[`PRS_SYS_DIAG],
                     input_swap:         pcfg_q[`PRS_PCFG_SWAP],
                     gain:               pcfg_q[`PRS_PCFG_GAIN_HI:`PRS_PCFG_GAIN_LO],
                     oversampling_field: pcfg_q[`PRS_PCFG_OSR_HI:`PRS_PCFG_OSR_LO],
                     start:              (c_st_q == C_TEMP) | (c_st_q == C_PRES),
                     chan_pres:          (c_st_q == C_PRES)};

  always_comb begin
    c_st_d  = c_st_q;
    clr_sco = 1'b0;
    case (c_st_q)
      C_IDLE: begin
        if (conv_go) begin
          c_st_d = C_TEMP;
        end else if (sco) begin
          clr_sco = 1'b1;
        end
      end
      C_TEMP: if (afe_res.done) begin
        c_st_d = C_PRES;
      end
      C_PRES: if (afe_res.done) begin
        if (periodic & sco) begin
          c_st_d = (idle == 4'h0) ? C_TEMP : C_SLEEP;
        end else begin
          c_st_d  = C_IDLE;
          clr_sco = 1'b1;
        end
      end
      C_SLEEP: begin
        if (!(periodic & sco)) begin
          c_st_d  = C_IDLE;
          clr_sco = 1'b1;
        end else if (step_end & (slp_q == 4'h1)) begin
          c_st_d = C_TEMP;
        end
      end
      default: c_st_d = C_IDLE;
    endcase
  end
  // A write of the command register wins over the self-clear
  assign cmd_d = wr_cmd ? req_q.wdata : (clr_sco ? (cmd_q & 8'hf7) : cmd_q);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {rq_s1, rq_s2, rq_s3} <= 3'h0;
      ack_tgl_q <= 1'b0;
      rdata_q   <= 8'h00;
      cmd_q     <= `PRS_CMD_RST;
      sys_q     <= `PRS_SYS_RST;
      pcfg_q    <= `PRS_PCFG_RST;
      c_st_q    <= C_IDLE;
    end else begin
      {rq_s1, rq_s2, rq_s3} <= {rq_tgl_q, rq_s1, rq_s2};
      ack_tgl_q <= ack_tgl_q ^ new_req;
      rdata_q   <= new_req ? rd_val : rdata_q;
      cmd_q     <= cmd_d;
      sys_q     <= (wr_en & (req_q.waddr == `PRS_OFF_SYS)) ? req_q.wdata : sys_q;
      pcfg_q    <= (wr_en & (req_q.waddr == `PRS_OFF_PCFG)) ? req_q.wdata : pcfg_q;
      c_st_q    <= c_st_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pres_q <= `PRS_RES_RST;
      temp_q <= 16'h0000;
      step_q <= 32'h0000_0000;
      slp_q  <= 4'h0;
    end else begin
      pres_q <= ((c_st_q == C_PRES) & afe_res.done) ? pres_v : pres_q;
      temp_q <= ((c_st_q == C_TEMP) & afe_res.done) ? temp_v[15:0] : temp_q;
      if (c_st_q != C_SLEEP) begin
        step_q <= 32'h0000_0000;
        slp_q  <= idle;
      end else begin
        step_q <= step_end ? 32'h0000_0000 : step_q + 32'h0000_0001;
        slp_q  <= step_end ? slp_q - 4'h1 : slp_q;
      end
    end
  end

  // Checks
  sequence s_temp_done;
    (c_st_q == C_TEMP) && afe_res.done;
  endsequence
  sequence s_pres_done;
    (c_st_q == C_PRES) && afe_res.done;
  endsequence
  AST_START_ADDR: assert property (@(posedge link_clk) disable iff (rst)
    start |=> (st_q == L_ADDR) && (cnt_q == 3'h0))
    else $error("start not followed by address phase");
  AST_STOP_IDLE: assert property (@(posedge link_clk) disable iff (rst)
    stop |=> (st_q == L_IDLE) && sda_oe_n)
    else $error("stop did not release the link");
  AST_ADDR_ACK: assert property (@(posedge link_clk) disable iff (rst)
    ((st_q == L_ADDR) && rise && (cnt_q == 3'h7) && adr_hit && !stop && !start)
      |-> ##[1:40] !sda_oe_n)
    else $error("own address not acknowledged");
  AST_NO_FOREIGN_ACK: assert property (@(posedge link_clk) disable iff (rst)
    ((st_q == L_ADDR) && rise && (cnt_q == 3'h7) && !adr_hit && !start && !stop)
      |=> (st_q == L_IDLE))
    else $error("foreign address taken");
  AST_SDA_STABLE: assert property (@(posedge link_clk) disable iff (rst)
    $changed(drv_q) |-> ($past(fall) || $past(start) || $past(stop)))
    else $error("data line changed outside clock low");
  AST_COMBINED: assert property (@(posedge clock) disable iff (rst)
    conv_go |=> (c_st_q == C_TEMP) && afe_ctl.start && !afe_ctl.chan_pres)
    else $error("combined conversion did not begin with temperature");
  AST_TEMP_RESULT: assert property (@(posedge clock) disable iff (rst)
    s_temp_done |=> (c_st_q == C_PRES) && (temp_q == $past(temp_v[15:0])))
    else $error("temperature result not stored");
  AST_PRES_RESULT: assert property (@(posedge clock) disable iff (rst)
    s_pres_done |=> (pres_q == $past(pres_v)))
    else $error("pressure result not stored");
  AST_SCO_CLEAR: assert property (@(posedge clock) disable iff (rst)
    (s_pres_done and (!periodic && !wr_cmd)) |=> !sco && (c_st_q == C_IDLE))
    else $error("start bit not cleared after single conversion");
  AST_PERIODIC: assert property (@(posedge clock) disable iff (rst)
    (s_pres_done and (periodic && sco && (idle != 4'h0) && !wr_cmd))
      |=> (c_st_q == C_SLEEP) && sco && (slp_q == $past(idle)))
    else $error("periodic mode did not enter idle interval");
  AST_UNSIGNED: assert property (@(posedge clock) disable iff (rst)
    (s_pres_done and (use_raw && unip)) |=> (pres_q[23] == ~$past(afe_res.raw[23])))
    else $error("unsigned raw format wrong");
  AST_READ_MAP: assert property (@(posedge clock) disable iff (rst)
    (new_req && (ra == `PRS_OFF_PRES_H)) |=> (rdata_q == $past(pres_q[23:16])))
    else $error("pressure high byte read wrong");
endmodule

//--- common/prs_defs.svh
// Offsets, field positions, reset values and timing figures of the readout
// Included by the package users; definitions only
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH

// Target address as shipped
`define PRS_I2C_ADDR      7'h6d

// Register offsets
`define PRS_OFF_PRES_H    8'h06
`define PRS_OFF_PRES_M    8'h07
`define PRS_OFF_PRES_L    8'h08
`define PRS_OFF_TEMP_H    8'h09
`define PRS_OFF_TEMP_L    8'h0a
`define PRS_OFF_CMD       8'h30
`define PRS_OFF_SYS       8'ha5
`define PRS_OFF_PCFG      8'ha6

// Reset values
`define PRS_CMD_RST       8'h00
`define PRS_SYS_RST       8'h01
`define PRS_PCFG_RST      8'h00
`define PRS_RES_RST       24'h00_0000

// Command fields
`define PRS_CMD_IDLE_HI   7
`define PRS_CMD_IDLE_LO   4
`define PRS_CMD_SCO       3
`define PRS_CMD_MODE_HI   2
`define PRS_CMD_MODE_LO   0
`define PRS_MODE_SINGLE   3'h2
`define PRS_MODE_PERIOD   3'h3

// System configuration fields
`define PRS_SYS_LDO       3
`define PRS_SYS_UNIP      2
`define PRS_SYS_RAW       1
`define PRS_SYS_DIAG      0

// Pressure channel configuration fields
`define PRS_PCFG_SWAP     7
`define PRS_PCFG_GAIN_HI  5
`define PRS_PCFG_GAIN_LO  3
`define PRS_PCFG_OSR_HI   2
`define PRS_PCFG_OSR_LO   0

// Sign masks
`define PRS_PRES_MSB      24'h80_0000
`define PRS_TEMP_MSB      24'h00_8000

// Timing: idle step of 62.5 ms, system clock rate
`define PRS_IDLE_STEP_US  62500
`define PRS_CLK_MHZ       100

`endif

//--- common/prs_pkg.sv
// Types shared by the pressure readout and its bench
// Constants live in prs_defs.svh
package prs_pkg;

  typedef enum logic [2:0] {
    L_IDLE = 3'h0,
    L_ADDR = 3'h1,
    L_ACK  = 3'h2,
    L_RX   = 3'h3,
    L_TX   = 3'h4,
    L_MACK = 3'h5,
    L_TXW  = 3'h6
  } prs_link_st_t;

  typedef enum logic [1:0] {
    C_IDLE  = 2'h0,
    C_TEMP  = 2'h1,
    C_PRES  = 2'h2,
    C_SLEEP = 2'h3
  } prs_conv_st_t;

  // Link to register side request, held stable until answered
  typedef struct packed {
    logic       we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] raddr;
  } prs_req_t;

  // Controls toward the analog front end
  typedef struct packed {
    logic       regulator_select;
    logic       diag_en;
    logic       input_swap;
    logic [2:0] gain;
    logic [2:0] oversampling_field;
    logic       start;
    logic       chan_pres;
  } prs_afe_ctl_t;

  // Answer from the analog front end
  typedef struct packed {
    logic        done;
    logic [23:0] raw;
    logic [23:0] cal;
  } prs_afe_res_t;

endpackage

//--- dv/prs_i2c_host.sv
// Bus controller model: drives SCL and releases or pulls SDA
// Assumes an SDA pull-up resolved by the bench and the target at the shipped address
`timescale 1ns/1ps
`include "prs_defs.svh"

module prs_i2c_host (
  // Bus lines
  output logic      scl_line,
  output logic      sda_drive,
  input  wire logic sda_line
);
  localparam time Q = 650;

  initial begin
    scl_line = 1'b1;
    sda_drive = 1'b1;
  end

  task automatic put_bit(input logic b, output logic s);
    scl_line = 1'b0;
    #Q sda_drive = b;
    #Q scl_line = 1'b1;
    #(Q/2) s = sda_line;
    #(Q/2);
  endtask

  task automatic start_cond();
    scl_line = 1'b0;
    #Q sda_drive = 1'b1;
    #Q scl_line = 1'b1;
    #Q sda_drive = 1'b0;
    #Q;
  endtask

  task automatic stop_cond();
    scl_line = 1'b0;
    #Q sda_drive = 1'b0;
    #Q scl_line = 1'b1;
    #Q sda_drive = 1'b1;
    #Q;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, nak);
  endtask

  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    d = '0;
    for (int i = 0; i < 8; i++) begin
      put_bit(1'b1, s);
      d = {d[6:0], s};
    end
    put_bit(last, s);
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [15:0] d, input int n,
                        output logic [3:0] nak);
    nak = '0;
    start_cond();
    send_byte({`PRS_I2C_ADDR, 1'b0}, nak[3]);
    send_byte(idx, nak[2]);
    for (int i = 0; i < n; i++) send_byte(d[15-8*i -: 8], nak[1-i]);
    stop_cond();
  endtask

  task automatic rd_reg(input logic [7:0] idx, input int n, output logic [39:0] v,
                        output logic [2:0] nak);
    logic [7:0] b;
    v = '0;
    start_cond();
    send_byte({`PRS_I2C_ADDR, 1'b0}, nak[2]);
    send_byte(idx, nak[1]);
    start_cond();
    send_byte({`PRS_I2C_ADDR, 1'b1}, nak[0]);
    for (int i = 0; i < n; i++) begin
      get_byte(i == n - 1, b);
      v = {v[31:0], b};
    end
    stop_cond();
  endtask
endmodule

//--- dv/test_prs_readout.sv
// Bench for the pressure readout: register traffic over the bus, front end model
// Assumes the bus controller model and the shared package and defines
`timescale 1ns/1ps
`include "prs_defs.svh"

module test_prs_readout;
  import prs_pkg::*;
  localparam int STEP = 20;
  localparam logic [23:0] P_RAW = 24'h81_2345;
  localparam logic [23:0] P_CAL = 24'hf0_abcd;
  localparam logic [23:0] T_RAW = 24'h00_8765;
  localparam logic [23:0] T_CAL = 24'h00_1a80;

  logic         clock, rst, link_clk, scl_line, sda_drive, sda_o, sda_oe_n;
  logic         fire, nak1;
  logic         prev_chan = 1'b1;
  logic [39:0]  v;
  wire          sda_line;
  prs_afe_ctl_t afe_ctl;
  prs_afe_res_t afe_res;
  int           err_count, compares, pres_cnt, busy, idle_cyc, last_gap, n0;

  assign sda_line = sda_drive & (sda_oe_n | sda_o);

  prs_readout #(.STEP_CYC(STEP)) i_prs_readout (
    .clock(clock), .rst(rst), .link_clk(link_clk), .scl_i(scl_line), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .afe_ctl(afe_ctl), .afe_res(afe_res));

  prs_i2c_host i_prs_i2c_host (
    .scl_line(scl_line), .sda_drive(sda_drive), .sda_line(sda_line));

  initial clock = 1'b0;
  always #5 clock = ~clock;
  initial begin
    link_clk = 1'b0;
    #37;
    forever #62.5 link_clk = ~link_clk;
  end

  task automatic close_out();
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d, input int n);
    logic [3:0] nak;
    i_prs_i2c_host.wr_reg(idx, d, n, nak);
    chk("write acknowledge", 40'h0, {36'h0, nak});
  endtask

  task automatic rd(input logic [7:0] idx, input int n, output logic [39:0] r);
    logic [2:0] nak;
    i_prs_i2c_host.rd_reg(idx, n, r, nak);
    chk("read acknowledge", 40'h0, {37'h0, nak});
  endtask

  task automatic wait_pres(input int n);
    for (int i = 0; i < 20000 && pres_cnt < n; i++) @(negedge clock);
    if (pres_cnt < n) begin
      err_count++;
      $display("mismatch pressure conversions expected %0d seen %0d", n, pres_cnt);
      close_out();
    end
  endtask

  function automatic logic [39:0] ctl();
    return {30'h0, afe_ctl.start, afe_ctl.regulator_select, afe_ctl.diag_en,
            afe_ctl.input_swap, afe_ctl.gain, afe_ctl.oversampling_field};
  endfunction

  // Front end: answers each request after four cycles
  always @(negedge clock) begin
    fire = (afe_ctl.start === 1'b1) && (busy == 3);
    if (afe_ctl.start !== 1'b1) begin
      busy = 0;
      idle_cyc++;
    end else if (fire) busy = 0;
    else busy++;
    afe_res.done = fire;
    afe_res.raw = afe_ctl.chan_pres ? P_RAW : T_RAW;
    afe_res.cal = afe_ctl.chan_pres ? P_CAL : T_CAL;
    if (fire && afe_ctl.chan_pres === 1'b1) begin
      chk("temperature before pressure", 40'h0, {39'h0, prev_chan});
      pres_cnt++;
      idle_cyc = 0;
    end else if (afe_ctl.start === 1'b1 && idle_cyc > 0) begin
      last_gap = idle_cyc;
      idle_cyc = 0;
    end
    if (fire) prev_chan = afe_ctl.chan_pres;
  end

  // Data line moves only while the clock line is low
  always @(sda_oe_n) begin
    if (rst === 1'b0 && scl_line === 1'b1) begin
      err_count++;
      $display("mismatch data line change expected scl low seen scl high");
    end
  end

  initial begin
    rst = 1'b1;
    repeat (40) @(negedge clock);
    rst = 1'b0;
    repeat (100) @(negedge clock);
    chk("controls at reset", 40'h080, ctl());
    rd(8'ha4, 3, v);
    chk("unmapped and config reset", 40'h00_0000_0100, v);
    i_prs_i2c_host.start_cond();
    i_prs_i2c_host.send_byte({7'h6c, 1'b0}, nak1);
    i_prs_i2c_host.stop_cond();
    chk("foreign address acknowledge", 40'h1, {39'h0, nak1});
    wr(`PRS_OFF_CMD, 16'h0a00, 1);
    for (int i = 0; i < 5; i++) begin
      rd(`PRS_OFF_CMD, 1, v);
      if (v[3] === 1'b0) break;
    end
    chk("start bit self clear", 40'h02, v);
    chk("one combined conversion", 40'h1, 40'(pres_cnt));
    rd(`PRS_OFF_PRES_H, 5, v);
    chk("calibrated results", {P_CAL, T_CAL[15:0]}, v);
    wr(`PRS_OFF_SYS, 16'h0ead, 2);
    chk("controls after config", 40'h16d, ctl());
    wr(`PRS_OFF_CMD, 16'h0a00, 1);
    wait_pres(2);
    rd(`PRS_OFF_PRES_H, 1, v);
    chk("unsigned raw pressure high", 40'h01, v);
    wr(`PRS_OFF_CMD, 16'h2b00, 1);
    wait_pres(5);
    chk("sleep interval", 40'h1,
        {39'h0, last_gap >= 2 * STEP - 1 && last_gap <= 2 * STEP + 3});
    rd(`PRS_OFF_CMD, 1, v);
    chk("start bit held in periodic mode", 40'h2b, v);
    // Start bit with an undecoded mode: periodic run ends, bit clears
    wr(`PRS_OFF_CMD, 16'h0800, 1);
    repeat (200) @(negedge clock);
    n0 = pres_cnt;
    repeat (300) @(negedge clock);
    chk("periodic stopped", 40'(n0), 40'(pres_cnt));
    rd(`PRS_OFF_CMD, 1, v);
    chk("start bit cleared with no mode", 40'h00, v);
    close_out();
  end
endmodule
